// ### rtl/drpa_pkg.sv
// Package: register map, field layout and types for the request pin activation channel
package drpa_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] OFF_CTRL = 12'h000;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 12'h004;
  localparam logic [ADDR_W-1:0] OFF_INT_STAT = 12'h008;
  localparam logic [ADDR_W-1:0] OFF_INT_MASK = 12'h00c;
  // Control word bit positions
  localparam int CTRL_XFER_ENABLE = 0;
  localparam int CTRL_PIN_REQ_EN = 1;
  localparam int CTRL_LEVEL_SENSE = 2;
  localparam int CTRL_NEXT_REQ_DELAY = 3;
  localparam int CTRL_SINGLE_ADDR = 4;
  localparam int CTRL_W = 5;
  // Interrupt event bit positions
  localparam int INT_DONE = 0;
  localparam int INT_ERR_STOP = 1;
  localparam int INT_W = 2;
  // Status word bit positions
  localparam int STAT_ACTIVE = 0;
  localparam int STAT_PENDING = 1;
  localparam int STAT_ARMED = 2;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 5'h00;
  localparam logic [INT_W-1:0] INT_RESET = 2'h0;
  // Request pin synchroniser depth and the idle level the synchroniser resets to
  localparam int SYNC_STAGES = 2;
  localparam logic REQ_IDLE_LEVEL = 1'b1;

  typedef struct packed {
    logic single_addr;
    logic next_request_delay;
    logic level_sense;
    logic pin_req_en;
    logic channel_xfer_enable;
  } drpa_ctrl_s;

  typedef struct packed {
    logic [ADDR_W-1:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [DATA_W-1:0] pwdata;
  } drpa_apb_req_s;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WAIT,
    ST_ACTIVE,
    ST_DELAY
  } drpa_state_e;
endpackage : drpa_pkg

// ### rtl/drpa_channel.sv
// One transfer channel: request pin sensing, activation sequencing and APB registers
//
// The register addresses and the APB interface to the registers were chosen for this implementation.
module drpa_channel (
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic CE,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [drpa_pkg::ADDR_W-1:0] PADDR,
  input wire logic [drpa_pkg::DATA_W-1:0] PWDATA,
  output logic PREADY,
  output logic [drpa_pkg::DATA_W-1:0] PRDATA,
  output logic PSLVERR,
  input wire logic EXT_REQUEST_N,
  input wire logic GRANT,
  input wire logic CYCLE_DONE,
  input wire logic LAST_UNIT,
  input wire logic ERROR_STOP,
  output logic XFER_REQ,
  output logic CHANNEL_ACTIVE_FLAG,
  output logic BUS_RELEASE,
  output logic XFER_END_OUT_N,
  output logic IRQ
);
  drpa_pkg::drpa_apb_req_s apb;
  drpa_pkg::drpa_ctrl_s ctrl, next_ctrl;
  drpa_pkg::drpa_state_e state, next_state;
  logic [drpa_pkg::SYNC_STAGES-1:0] sync;
  logic [drpa_pkg::SYNC_STAGES-1:0] next_sync;
  logic next_active;
  logic pending, next_pending;
  logic seen_high, next_seen_high;
  logic [drpa_pkg::INT_W-1:0] int_stat, next_int_stat;
  logic [drpa_pkg::INT_W-1:0] int_mask, next_int_mask;
  logic next_pready, next_pslverr;
  logic [drpa_pkg::DATA_W-1:0] next_prdata;
  logic next_xfer_req, next_bus_release, next_end_n, next_irq;
  logic pin_low, armed, unit_done, finish, wr_ctrl, wr_stat, wr_mask, bus_write;
  logic [drpa_pkg::INT_W-1:0] events;

  // Address decode shared by the slave error check and write strobes
  function automatic logic hit(input logic [drpa_pkg::ADDR_W-1:0] a, input logic [drpa_pkg::ADDR_W-1:0] off);
    hit = (a == off);
  endfunction : hit

  function automatic logic mapped(input logic [drpa_pkg::ADDR_W-1:0] a);
    mapped = hit(a, drpa_pkg::OFF_CTRL) | hit(a, drpa_pkg::OFF_STATUS) |
             hit(a, drpa_pkg::OFF_INT_STAT) | hit(a, drpa_pkg::OFF_INT_MASK);
  endfunction : mapped

  // Bus signals grouped for the slave logic
  always_comb begin
    apb.paddr = PADDR;
    apb.psel = PSEL;
    apb.penable = PENABLE;
    apb.pwrite = PWRITE;
    apb.pwdata = PWDATA;
  end

  // Writes land only at the edge where pready is seen high
  always_comb begin
    bus_write = apb.psel & apb.penable & PREADY & apb.pwrite & mapped(apb.paddr);
    wr_ctrl = bus_write & hit(apb.paddr, drpa_pkg::OFF_CTRL);
    wr_stat = bus_write & hit(apb.paddr, drpa_pkg::OFF_INT_STAT);
    wr_mask = bus_write & hit(apb.paddr, drpa_pkg::OFF_INT_MASK);
  end

  // Synchroniser shift: stage 0 takes the pin, each later stage the one before
  always_comb begin
    next_sync[0] = EXT_REQUEST_N;
    for (int i = 1; i < drpa_pkg::SYNC_STAGES; i++) begin
      next_sync[i] = sync[i-1];
    end
  end

  // Two-flop synchroniser on the request pin; only the last stage is looked at
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      sync <= {drpa_pkg::SYNC_STAGES{drpa_pkg::REQ_IDLE_LEVEL}};
    end else if (CE) begin
      sync <= next_sync;
    end
  end

  // Sensing terms; edge mode needs a high seen since activation
  always_comb begin
    pin_low = ~sync[drpa_pkg::SYNC_STAGES-1];
    armed = ctrl.channel_xfer_enable & ctrl.pin_req_en & (ctrl.level_sense | seen_high);
    unit_done = (state == drpa_pkg::ST_ACTIVE) & CYCLE_DONE;
    finish = unit_done & (LAST_UNIT | ~ctrl.channel_xfer_enable | ERROR_STOP);
  end

  // Channel sequencer: wait, activate, run one unit, optional gap, repeat
  always_comb begin
    next_state = state;
    next_pending = pending;
    next_seen_high = seen_high;
    case (state)
      drpa_pkg::ST_IDLE: begin
        next_pending = 1'b0;
        next_seen_high = 1'b1;
        // Enable written one edge earlier; this edge moves to wait and sampling starts from the next edge
        if (ctrl.channel_xfer_enable) begin
          next_state = drpa_pkg::ST_WAIT;
        end
      end
      // Waiting: latch a request, or activate on grant
      drpa_pkg::ST_WAIT: begin
        if (!ctrl.channel_xfer_enable) begin
          next_state = drpa_pkg::ST_IDLE;
          next_pending = 1'b0;
        end else if (pending && GRANT) begin
          next_state = drpa_pkg::ST_ACTIVE;
          next_pending = 1'b0;
          next_seen_high = 1'b0;
        end else begin
          if (armed && pin_low) begin
            next_pending = 1'b1;
          end
          if (!pin_low) begin
            next_seen_high = 1'b1;
          end
        end
      end
      drpa_pkg::ST_ACTIVE: begin
        // A high during the unit re-arms edge mode; level mode ignores the pin here
        if (!pin_low) begin
          next_seen_high = 1'b1;
        end
        if (finish) begin
          next_state = drpa_pkg::ST_IDLE;
        end else if (unit_done) begin
          // Delay bit holds off acceptance one more cycle
          next_state = ctrl.next_request_delay ? drpa_pkg::ST_DELAY : drpa_pkg::ST_WAIT;
        end
      end
      // Blocking gap: the pin is watched for a high but no request is taken
      drpa_pkg::ST_DELAY: begin
        if (!pin_low) begin
          next_seen_high = 1'b1;
        end
        next_state = ctrl.channel_xfer_enable ? drpa_pkg::ST_WAIT : drpa_pkg::ST_IDLE;
      end
      // Unused encoding falls back to idle with the request cleared
      default: begin
        next_state = drpa_pkg::ST_IDLE;
        next_pending = 1'b0;
        next_seen_high = 1'b1;
      end
    endcase
  end

  // Sequencer state, held while the clock enable is low
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      state <= drpa_pkg::ST_IDLE;
      pending <= 1'b0;
      seen_high <= 1'b1;
    end else if (CE) begin
      state <= next_state;
      pending <= next_pending;
      seen_high <= next_seen_high;
    end
  end

  // Control register; hardware clear of enable wins over a software write
  always_comb begin
    next_ctrl = ctrl;
    if (wr_ctrl) begin
      next_ctrl = drpa_pkg::drpa_ctrl_s'(apb.pwdata[drpa_pkg::CTRL_W-1:0]);
    end
    // Error stop drops enable at once; active ends at the next unit done
    if (finish || ERROR_STOP) begin
      next_ctrl.channel_xfer_enable = 1'b0;
    end
  end

  // Control flops
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      ctrl <= drpa_pkg::drpa_ctrl_s'(drpa_pkg::CTRL_RESET);
    end else if (CE) begin
      ctrl <= next_ctrl;
    end
  end

  // Event sources: transfer finish and an error stop while enabled
  always_comb begin
    events = '0;
    events[drpa_pkg::INT_DONE] = finish;
    events[drpa_pkg::INT_ERR_STOP] = ERROR_STOP & ctrl.channel_xfer_enable;
  end

  // Sticky events, write one to clear; a new event beats the clear
  always_comb begin
    next_int_stat = int_stat;
    if (wr_stat) begin
      next_int_stat = int_stat & ~apb.pwdata[drpa_pkg::INT_W-1:0];
    end
    next_int_stat = next_int_stat | events;
    next_int_mask = wr_mask ? apb.pwdata[drpa_pkg::INT_W-1:0] : int_mask;
    // From the updated status so the output never lags a clear
    next_irq = |(next_int_stat & next_int_mask);
  end

  // Interrupt status, mask and output flops
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      int_stat <= drpa_pkg::INT_RESET;
      int_mask <= drpa_pkg::INT_RESET;
      IRQ <= 1'b0;
    end else if (CE) begin
      int_stat <= next_int_stat;
      int_mask <= next_int_mask;
      IRQ <= next_irq;
    end
  end

  // Pin-side outputs, all registered; request and active from the next state, release and end from this cycle's unit done
  always_comb begin
    next_xfer_req = next_pending;
    // Cycle stealing: the bus goes back after every unit that does not finish the transfer
    next_bus_release = unit_done & ~finish;
    next_end_n = ~finish;
    next_active = (next_state == drpa_pkg::ST_ACTIVE);
  end

  // Pin-side output flops
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      XFER_REQ <= 1'b0;
      CHANNEL_ACTIVE_FLAG <= 1'b0;
      BUS_RELEASE <= 1'b0;
      XFER_END_OUT_N <= 1'b1;
    end else if (CE) begin
      XFER_REQ <= next_xfer_req;
      CHANNEL_ACTIVE_FLAG <= next_active;
      BUS_RELEASE <= next_bus_release;
      XFER_END_OUT_N <= next_end_n;
    end
  end

  // APB answer: one wait state so pready and read data come from flops
  always_comb begin
    next_pready = 1'b0;
    next_pslverr = 1'b0;
    next_prdata = '0;
    if (apb.psel && apb.penable && !PREADY) begin
      next_pready = 1'b1;
      next_pslverr = ~mapped(apb.paddr);
      // Writes and unmapped reads leave the data at zero
      if (!apb.pwrite) begin
        case (apb.paddr)
          drpa_pkg::OFF_CTRL: begin
            next_prdata[drpa_pkg::CTRL_W-1:0] = ctrl;
          end
          drpa_pkg::OFF_STATUS: begin
            next_prdata[drpa_pkg::STAT_ACTIVE] = CHANNEL_ACTIVE_FLAG;
            next_prdata[drpa_pkg::STAT_PENDING] = pending;
            next_prdata[drpa_pkg::STAT_ARMED] = armed;
          end
          drpa_pkg::OFF_INT_STAT: begin
            next_prdata[drpa_pkg::INT_W-1:0] = int_stat;
          end
          drpa_pkg::OFF_INT_MASK: begin
            next_prdata[drpa_pkg::INT_W-1:0] = int_mask;
          end
          default: begin
            next_prdata = '0;
          end
        endcase
      end
    end
  end

  // APB answer flops
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA <= '0;
    end else if (CE) begin
      PREADY <= next_pready;
      PSLVERR <= next_pslverr;
      PRDATA <= next_prdata;
    end
  end
endmodule : drpa_channel

// ### tb/drpa_chk_sva.sv
// Checker: request sequencing and APB timing of the channel
module drpa_chk (
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PREADY,
  input wire logic EXT_REQUEST_N,
  input wire logic GRANT,
  input wire logic CYCLE_DONE,
  input wire logic XFER_REQ,
  input wire logic CHANNEL_ACTIVE_FLAG,
  input wire logic BUS_RELEASE,
  input wire logic XFER_END_OUT_N
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  // Activation needs a held request and the grant
  a_act_from_req: assert property ($rose(CHANNEL_ACTIVE_FLAG) |-> $past(XFER_REQ) && $past(GRANT))
    else $error("activation without held request");
  a_clear_on_act: assert property ($rose(CHANNEL_ACTIVE_FLAG) |-> !XFER_REQ)
    else $error("request not cleared on activation");
  // Synchroniser delay bounds where the low must have been seen
  a_req_from_pin: assert property ($rose(XFER_REQ) |->
    !$past(EXT_REQUEST_N, 3) || !$past(EXT_REQUEST_N, 4) || !$past(EXT_REQUEST_N, 5))
    else $error("request without low pin");
  a_active_ends: assert property ($fell(CHANNEL_ACTIVE_FLAG) |-> $past(CYCLE_DONE))
    else $error("active fell without cycle done");
  a_end_with_act: assert property (!XFER_END_OUT_N |-> $fell(CHANNEL_ACTIVE_FLAG))
    else $error("end pulse not with active fall");
  a_end_one_cyc: assert property ($fell(XFER_END_OUT_N) |=> XFER_END_OUT_N)
    else $error("end pulse longer than one cycle");
  a_release_unit: assert property (BUS_RELEASE |-> (XFER_END_OUT_N && $past(CYCLE_DONE)) ##1 !BUS_RELEASE)
    else $error("bus release misplaced");
  a_ready_access: assert property (PREADY |-> PSEL && PENABLE && $past(PENABLE))
    else $error("ready outside access phase");
endmodule : drpa_chk

bind drpa_channel drpa_chk u_chk (.MCLK(MCLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PREADY(PREADY),
  .EXT_REQUEST_N(EXT_REQUEST_N), .GRANT(GRANT), .CYCLE_DONE(CYCLE_DONE), .XFER_REQ(XFER_REQ),
  .CHANNEL_ACTIVE_FLAG(CHANNEL_ACTIVE_FLAG), .BUS_RELEASE(BUS_RELEASE), .XFER_END_OUT_N(XFER_END_OUT_N));

// ### tb/drpa_req_model.sv
// Partner model: external requester driving the active-low pin
module drpa_req_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic go,
  input wire logic [7:0] hold,
  output logic req_n
);
  logic [7:0] cnt;
  // Low from go for hold plus one cycles, then back to the idle high level
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      req_n <= 1'b1;
      cnt <= 8'h00;
    end else if (go) begin
      req_n <= 1'b0;
      cnt <= hold;
    end else if (cnt != 8'h00) begin
      cnt <= cnt - 8'h01;
    end else begin
      req_n <= 1'b1;
    end
  end
endmodule : drpa_req_model

// ### tb/tb.sv
// Testbench: pin sensing, delay gap, completion and interrupt
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic MCLK, RST_N, CE, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, EXT_REQUEST_N, GRANT, CYCLE_DONE;
  logic LAST_UNIT, ERROR_STOP, XFER_REQ, CHANNEL_ACTIVE_FLAG, BUS_RELEASE, XFER_END_OUT_N, IRQ, go;
  logic [11:0] PADDR;
  logic [31:0] PWDATA, PRDATA;
  logic [7:0] hold, lf;
  logic [32:0] expq[$];
  int n_mismatch, tests_run, g, g0;
  drpa_channel dut (.MCLK(MCLK), .RST_N(RST_N), .CE(CE), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY), .PRDATA(PRDATA), .PSLVERR(PSLVERR),
    .EXT_REQUEST_N(EXT_REQUEST_N), .GRANT(GRANT), .CYCLE_DONE(CYCLE_DONE), .LAST_UNIT(LAST_UNIT),
    .ERROR_STOP(ERROR_STOP), .XFER_REQ(XFER_REQ), .CHANNEL_ACTIVE_FLAG(CHANNEL_ACTIVE_FLAG),
    .BUS_RELEASE(BUS_RELEASE), .XFER_END_OUT_N(XFER_END_OUT_N), .IRQ(IRQ));
  drpa_req_model req (.clk(MCLK), .rst_n(RST_N), .go(go), .hold(hold), .req_n(EXT_REQUEST_N));
  // Free-running 100 MHz clock
  initial begin
    MCLK = 1'b0;
    forever #5 MCLK = ~MCLK;
  end
  function automatic logic [7:0] nx(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction : nx
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish
  // Read notes go to the queue; the extra edge keeps PSEL from two writes in one step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [32:0] e);
    if (!w) expq.push_back(e);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge MCLK);
    PENABLE <= 1'b1;
    @(posedge MCLK);
    // Only the watchdog ends a lost answer
    while (PREADY !== 1'b1) begin
      @(posedge MCLK);
    end
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge MCLK);
  endtask : apb
  task automatic pulse(input logic [7:0] h);
    go <= 1'b1;
    hold <= h;
    @(posedge MCLK);
    go <= 1'b0;
  endtask : pulse
  // One unit; gap to the next request is capped at 20 so a lost request cannot hang
  task automatic unit(input logic last);
    int n;
    n = 0;
    while (CHANNEL_ACTIVE_FLAG !== 1'b1 && n < 40) begin
      n++;
      @(posedge MCLK);
    end
    chk(33'(n < 40), 33'h1);
    CYCLE_DONE <= 1'b1;
    LAST_UNIT <= last;
    @(posedge MCLK);
    CYCLE_DONE <= 1'b0;
    LAST_UNIT <= 1'b0;
    @(posedge MCLK);
    chk(33'(BUS_RELEASE), 33'(!last));
    chk(33'(XFER_END_OUT_N), 33'(!last));
    chk(33'(CHANNEL_ACTIVE_FLAG), 33'h0);
    g = 0;
    while (XFER_REQ !== 1'b1 && g < 20) begin
      g++;
      @(posedge MCLK);
    end
  endtask : unit
  // Scoreboard: each read answer against the oldest note
  always @(posedge MCLK)
    if (PREADY === 1'b1 && !PWRITE) chk({PSLVERR, PRDATA}, expq.pop_front());
  // Watchdog: twenty times the expected run
  initial begin
    repeat (5000) @(posedge MCLK);
    n_mismatch++;
    tally_and_finish();
  end
  // Main sequence
  initial begin
    {RST_N, CE, PSEL, PENABLE, PWRITE, GRANT, CYCLE_DONE, LAST_UNIT, ERROR_STOP, go} = 10'h110;
    {PADDR, PWDATA, hold, lf, n_mismatch, tests_run} = {12'h000, 32'h0, 8'h00, 8'h5b, 64'h0};
    repeat (6) @(posedge MCLK);
    RST_N <= 1'b1;
    @(posedge MCLK);
    for (int i = 0; i < 5; i++) apb(1'b0, 12'(i * 4), 32'h0, {i == 4, 32'h0});
    lf = nx(lf);
    apb(1'b1, drpa_pkg::OFF_INT_MASK, {24'h0, lf}, 33'h0);
    apb(1'b0, drpa_pkg::OFF_INT_MASK, 32'h0, {31'h0, lf[1:0]});
    apb(1'b1, drpa_pkg::OFF_INT_MASK, 32'h1, 33'h0);
    $display("register test done");
    apb(1'b1, drpa_pkg::OFF_CTRL, 32'h3, 33'h0);
    pulse(8'd30);
    unit(1'b0);
    chk(33'(g), 33'd20);
    repeat (30) @(posedge MCLK);
    pulse(8'd200);
    unit(1'b0);
    chk(33'(g), 33'd20);
    $display("edge test done");
    apb(1'b1, drpa_pkg::OFF_CTRL, 32'h7, 33'h0);
    unit(1'b0);
    g0 = g;
    chk(33'(g0 < 20), 33'h1);
    apb(1'b1, drpa_pkg::OFF_CTRL, 32'hf, 33'h0);
    unit(1'b0);
    chk(33'(g), 33'(g0 + 1));
    $display("level test done");
    unit(1'b1);
    chk(33'(g), 33'd20);
    apb(1'b0, drpa_pkg::OFF_CTRL, 32'h0, 33'he);
    chk(33'(IRQ), 33'h1);
    apb(1'b1, drpa_pkg::OFF_INT_STAT, 32'h1, 33'h0);
    apb(1'b0, drpa_pkg::OFF_INT_STAT, 32'h0, 33'h0);
    chk(33'(IRQ), 33'h0);
    $display("completion test done");
    // Clock enable low right after enabling: no request may form while frozen
    pulse(8'd60);
    apb(1'b1, drpa_pkg::OFF_CTRL, 32'h7, 33'h0);
    CE <= 1'b0;
    repeat (5) @(posedge MCLK);
    chk(33'(XFER_REQ), 33'h0);
    CE <= 1'b1;
    unit(1'b1);
    chk(33'(IRQ), 33'h1);
    $display("freeze test done");
    // Error stop while waiting, single address mode
    pulse(8'd40);
    apb(1'b1, drpa_pkg::OFF_CTRL, 32'h17, 33'h0);
    ERROR_STOP <= 1'b1;
    @(posedge MCLK);
    ERROR_STOP <= 1'b0;
    apb(1'b0, drpa_pkg::OFF_INT_STAT, 32'h0, 33'h3);
    apb(1'b0, drpa_pkg::OFF_CTRL, 32'h0, 33'h16);
    chk(33'(CHANNEL_ACTIVE_FLAG), 33'h0);
    apb(1'b1, drpa_pkg::OFF_INT_STAT, 32'h3, 33'h0);
    chk(33'(IRQ), 33'h0);
    $display("error stop test done");
    tally_and_finish();
  end
endmodule : tb
